// ===== src/p1fs_port_select.v
`timescale 1ns/1ps
`default_nettype none
`include "p1fs_defs.vh"
module p1fs_port_select #(
  parameter NUM_PINS = `P1FS_NUM_PINS,
  parameter NUM_LCD  = `P1FS_NUM_LCD_PINS
) (
  // Clock and control
  input  wire                  clk,
  input  wire                  srst,
  input  wire                  ce,
  input  wire                  lcd_ref_select,
  // Per-pin configuration
  input  wire [NUM_PINS-1:0]   pin_direction_bit,
  input  wire [NUM_PINS-1:0]   pin_function_select,
  input  wire [NUM_PINS*5-1:0] port_mapping_code,
  input  wire [NUM_LCD-1:0]    lcd_segment_enable,
  // Data from the core
  input  wire [NUM_PINS-1:0]   gpio_out,
  input  wire [NUM_PINS-1:0]   mapped_out,
  input  wire [NUM_PINS-1:0]   mapped_oe,
  // Pad side
  input  wire [NUM_PINS-1:0]   pad_in,
  output reg  [NUM_PINS-1:0]   pad_out,
  output reg  [NUM_PINS-1:0]   pad_oe,
  output reg  [NUM_PINS-1:0]   schmitt_en,
  // Digital input towards the core
  output reg  [NUM_PINS-1:0]   gpio_in,
  output reg  [NUM_PINS-1:0]   mapped_in,
  // Analog routing
  output reg  [NUM_LCD-1:0]    lcd_segment_line,
  output reg                   lcd_bias_node_high,
  output reg                   lcd_bias_node_mid,
  output reg                   lcd_bias_node_low,
  output reg                   lcd_reference_input,
  // Current function per pin, one-hot
  output reg  [NUM_PINS*5-1:0] pin_function
);
  wire [NUM_PINS*5-1:0] fn_w;
  wire [NUM_PINS-1:0]   de_w;
  wire [NUM_PINS-1:0]   dv_w;
  wire [NUM_PINS-1:0]   st_w;
  reg  [NUM_PINS-1:0]   sync1_reg;
  reg  [NUM_PINS-1:0]   sync2_reg;
  reg  [NUM_PINS-1:0]   sync3_reg;
  reg  [NUM_PINS-1:0]   in_reg;
  reg                   ref_sel_reg;
  wire [NUM_PINS-1:0]   seg_w;
  // Separate loop variables, one per process, so no variable has two drivers
  integer               k_s;
  integer               k_o;
  integer               k_l;

  // True when a pin's one-hot function equals the given code
  function fn_is;
    input [4:0] fn;
    input [4:0] code;
    begin
      fn_is = (fn == code);
    end
  endfunction

  // One independent cell per pin
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i = i + 1)
    begin : g_pin
      // Upper pins have no segment enable; tie theirs off instead of indexing past the bus
      if (i < NUM_LCD)
      begin : g_seg
        assign seg_w[i] = lcd_segment_enable[i];
      end
      else
      begin : g_noseg
        assign seg_w[i] = 1'b0;
      end

      p1fs_pin_cell #(
        .HAS_LCD_SEG ((i < NUM_LCD) ? 1 : 0)
      ) u_cell (
        .pin_direction_bit   (pin_direction_bit[i]),
        .pin_function_select (pin_function_select[i]),
        .port_mapping_code   (port_mapping_code[i*5 +: 5]),
        .lcd_segment_enable  (seg_w[i]),
        .gpio_out            (gpio_out[i]),
        .mapped_out          (mapped_out[i]),
        .mapped_oe           (mapped_oe[i]),
        .function_code       (fn_w[i*5 +: 5]),
        .drive_en            (de_w[i]),
        .drive_val           (dv_w[i]),
        .schmitt_en          (st_w[i])
      );
    end
  endgenerate

  // Pad inputs are asynchronous: three stages, change accepted when 2 and 3 agree
  // A glitch shorter than two edges never reaches the core
  always @(posedge clk)
  begin
    if (srst)
    begin
      sync1_reg <= {NUM_PINS{1'b0}};
      sync2_reg <= {NUM_PINS{1'b0}};
      sync3_reg <= {NUM_PINS{1'b0}};
      in_reg    <= {NUM_PINS{1'b0}};
    end
    else if (ce)
    begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (k_s = 0; k_s < NUM_PINS; k_s = k_s + 1)
        if (sync2_reg[k_s] == sync3_reg[k_s])
          in_reg[k_s] <= sync3_reg[k_s];
    end
  end

  // Pad drive and Schmitt enables, one edge behind the controls
  always @(posedge clk)
  begin
    if (srst)
    begin
      pad_out    <= {NUM_PINS{1'b0}};
      pad_oe     <= {NUM_PINS{1'b0}};
      schmitt_en <= {NUM_PINS{1'b0}};
    end
    else if (ce)
    begin
      pad_oe     <= de_w;
      pad_out    <= dv_w;
      schmitt_en <= st_w;
    end
  end

  // One-hot function report per pin
  always @(posedge clk)
  begin
    if (srst)
    begin
      pin_function <= {NUM_PINS{`P1FS_FN_GPIO}};
    end
    else if (ce)
    begin
      pin_function <= fn_w;
    end
  end

  // Input towards the core; a disabled Schmitt trigger reads as zero
  always @(posedge clk)
  begin
    if (srst)
    begin
      gpio_in   <= {NUM_PINS{1'b0}};
      mapped_in <= {NUM_PINS{1'b0}};
    end
    else if (ce)
    begin
      for (k_o = 0; k_o < NUM_PINS; k_o = k_o + 1)
      begin
        gpio_in[k_o]   <= st_w[k_o] & in_reg[k_o]
                          & fn_is(fn_w[k_o*5 +: 5], `P1FS_FN_GPIO);
        mapped_in[k_o] <= st_w[k_o] & in_reg[k_o]
                          & fn_is(fn_w[k_o*5 +: 5], `P1FS_FN_MAPPED);
      end
    end
  end

  // LCD routing; the reference choice is registered, so it lands two edges after lcd_ref_select
  always @(posedge clk)
  begin
    if (srst)
    begin
      lcd_segment_line    <= {NUM_LCD{1'b0}};
      lcd_bias_node_high  <= 1'b0;
      lcd_bias_node_mid   <= 1'b0;
      lcd_bias_node_low   <= 1'b0;
      lcd_reference_input <= 1'b0;
      ref_sel_reg         <= 1'b0;
    end
    else if (ce)
    begin
      for (k_l = 0; k_l < NUM_LCD; k_l = k_l + 1)
        lcd_segment_line[k_l] <= fn_is(fn_w[k_l*5 +: 5], `P1FS_FN_LCDSEG);
      // Upper pins: bias taps, middle one may double as reference input
      lcd_bias_node_high  <= fn_is(fn_w[(NUM_PINS-3)*5 +: 5], `P1FS_FN_LCDBIAS);
      lcd_bias_node_mid   <= fn_is(fn_w[(NUM_PINS-2)*5 +: 5], `P1FS_FN_LCDBIAS)
                             & ~ref_sel_reg;
      lcd_bias_node_low   <= fn_is(fn_w[(NUM_PINS-1)*5 +: 5], `P1FS_FN_LCDBIAS);
      lcd_reference_input <= fn_is(fn_w[(NUM_PINS-2)*5 +: 5], `P1FS_FN_LCDBIAS)
                             & ref_sel_reg;
      ref_sel_reg         <= lcd_ref_select;
    end
  end
endmodule
`default_nettype wire

// ===== common/p1fs_defs.vh
`ifndef P1FS_DEFS_VH
`define P1FS_DEFS_VH
// Port geometry
`define P1FS_NUM_PINS      8
`define P1FS_NUM_LCD_PINS  5
`define P1FS_MAP_W         5
// Mapping code limits
`define P1FS_MAP_DIGITAL_MAX 5'h1E
`define P1FS_MAP_ANALOG      5'h1F
// Direction encoding
`define P1FS_DIR_IN  1'h0
`define P1FS_DIR_OUT 1'h1
// Reset values of control state
`define P1FS_RST_BYTE 8'h00
// Function codes (one-hot), per pin
`define P1FS_FN_W       5
`define P1FS_FN_GPIO    5'h01
`define P1FS_FN_MAPPED  5'h02
`define P1FS_FN_OFF     5'h04
`define P1FS_FN_LCDSEG  5'h08
`define P1FS_FN_LCDBIAS 5'h10
`endif

// ===== src/p1fs_pin_cell.v
`timescale 1ns/1ps
`default_nettype none
`include "p1fs_defs.vh"
// Combinational decision for a single pin; no state shared between pins
module p1fs_pin_cell #(
  parameter HAS_LCD_SEG = 1
) (
  // Pin controls
  input  wire       pin_direction_bit,
  input  wire       pin_function_select,
  input  wire [4:0] port_mapping_code,
  input  wire       lcd_segment_enable,
  // Data sources
  input  wire       gpio_out,
  input  wire       mapped_out,
  input  wire       mapped_oe,
  // Decision
  output reg  [4:0] function_code,
  output reg        drive_en,
  output reg        drive_val,
  output reg        schmitt_en
);
  wire is_analog;
  assign is_analog = (port_mapping_code == `P1FS_MAP_ANALOG);

  // Priority: LCD segment, then select, then plain I/O
  always @*
  begin
    function_code = `P1FS_FN_GPIO;
    drive_en      = 1'b0;
    drive_val     = 1'b0;
    schmitt_en    = 1'b1;
    if (HAS_LCD_SEG != 0 && lcd_segment_enable)
    begin
      function_code = `P1FS_FN_LCDSEG;
      schmitt_en    = 1'b0;
    end
    else if (pin_function_select && is_analog)
    begin
      // Analog code never loads the pad, whichever pin this is
      function_code = (HAS_LCD_SEG != 0) ? `P1FS_FN_OFF : `P1FS_FN_LCDBIAS;
      schmitt_en    = 1'b0;
    end
    else if (pin_function_select)
    begin
      function_code = `P1FS_FN_MAPPED;
      drive_en      = mapped_oe;
      drive_val     = mapped_out;
    end
    else
    begin
      drive_en  = (pin_direction_bit == `P1FS_DIR_OUT);
      drive_val = gpio_out;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/p1fs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module p1fs_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  // Configuration
  input wire logic [7:0]  pin_direction_bit,
  input wire logic [7:0]  pin_function_select,
  input wire logic [39:0] port_mapping_code,
  input wire logic [4:0]  lcd_segment_enable,
  input wire logic [7:0]  mapped_oe,
  // Results
  input wire logic [7:0]  pad_oe,
  input wire logic [7:0]  schmitt_en,
  input wire logic [4:0]  lcd_segment_line,
  input wire logic        lcd_bias_node_high,
  input wire logic        lcd_bias_node_low,
  input wire logic [39:0] pin_function
);
  logic       armed_reg;
  wire  [7:0] sel = pin_function_select;
  wire  [39:0] cd = port_mapping_code;
  wire  [4:0] seg = lcd_segment_enable;
  // Past inputs count only after an enabled edge outside reset
  always @(posedge clk) armed_reg <= !srst && ce;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_gpio_dir: assert property (armed_reg && !$past(sel[0]) && !$past(seg[0])
    |-> pad_oe[0] == $past(pin_direction_bit[0])) else $error("gpio direction wrong");
  a_gpio_code: assert property (armed_reg && !$past(sel[7])
    |-> pin_function[39:35] == 5'h01) else $error("gpio code wrong");
  a_mapped_dir: assert property (armed_reg && $past(sel[1]) && $past(cd[9:5]) <= 5'h1E
    && !$past(seg[1]) |-> pad_oe[1] == $past(mapped_oe[1]) && pin_function[9:5] == 5'h02)
    else $error("mapped pin wrong");
  a_off_lower: assert property (armed_reg && $past(sel[2]) && $past(cd[14:10]) == 5'h1F
    && !$past(seg[2]) |-> !pad_oe[2] && !schmitt_en[2] && pin_function[14:10] == 5'h04)
    else $error("disabled pin still active");
  a_lcd_seg: assert property (armed_reg && $past(seg[4])
    |-> lcd_segment_line[4] && !pad_oe[4] && pin_function[24:20] == 5'h08)
    else $error("segment pin wrong");
  a_bias_high: assert property (armed_reg
    |-> lcd_bias_node_high == ($past(sel[5]) && $past(cd[29:25]) == 5'h1F))
    else $error("high bias wrong");
  a_bias_low: assert property (armed_reg
    |-> lcd_bias_node_low == ($past(sel[7]) && $past(cd[39:35]) == 5'h1F))
    else $error("low bias wrong");
  a_analog_off: assert property (armed_reg && $past(sel[6]) && $past(cd[34:30]) == 5'h1F
    |-> !pad_oe[6] && !schmitt_en[6]) else $error("analog pin loaded");
endmodule
`default_nettype wire

// ===== testbench/p1fs_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module p1fs_far_side (
  // Clock and pad drive
  input wire logic  clk,
  input wire logic  hold,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  // Pad level and core data
  output logic [7:0] pad_in,
  output logic [7:0] gpio_out,
  output logic [7:0] mapped_out
);
  logic [7:0] cnt_reg = 8'h00;
  // Released pads follow a count that steps every cycle; pad 0 toggles each cycle, higher pads more slowly
  // Hold freezes the levels so the bench can compare exactly
  always @(posedge clk) if (!hold) cnt_reg <= cnt_reg + 8'h01;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & cnt_reg);
  assign gpio_out = cnt_reg ^ 8'h5A;
  assign mapped_out = ~cnt_reg;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] sel, dir; logic [4:0] seg, cd; logic [7:0] moe, oe;
    logic [39:0] fn;} p1fs_row_t;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, hold = 1'b0, ref_sel = 1'b0;
  logic [7:0] dir = 8'h00, sel = 8'h00, moe = 8'h00;
  logic [4:0] seg = 5'h00;
  logic [39:0] cd = 40'h0;
  wire [7:0] pad_in, gpio_out, mapped_out, pad_out, pad_oe, sch, gin, min;
  wire [4:0] lsl;
  wire bh, bm, bl, lri;
  wire [39:0] fn;
  int n_mismatch = 0, cmp_count = 0;
  p1fs_row_t rows [7] = '{
    '{8'h00, 8'hA5, 5'h00, 5'h00, 8'h00, 8'hA5, {8{5'h01}}},
    '{8'hFF, 8'h00, 5'h00, 5'h1E, 8'h3C, 8'h3C, {8{5'h02}}},
    '{8'hFF, 8'hFF, 5'h00, 5'h00, 8'hC3, 8'hC3, {8{5'h02}}},
    '{8'hFF, 8'hFF, 5'h00, 5'h1F, 8'hFF, 8'h00, {{3{5'h10}}, {5{5'h04}}}},
    '{8'h00, 8'hFF, 5'h1F, 5'h00, 8'h00, 8'hE0, {{3{5'h01}}, {5{5'h08}}}},
    '{8'h0F, 8'hF0, 5'h00, 5'h1F, 8'hFF, 8'hF0, {{4{5'h01}}, {4{5'h04}}}},
    '{8'hFF, 8'hFF, 5'h1F, 5'h1F, 8'h00, 8'h00, {{3{5'h10}}, {5{5'h08}}}}};
  always #25 clk = ~clk;
  p1fs_port_select p1fs_port_select_i (.clk(clk), .srst(srst), .ce(ce), .lcd_ref_select(ref_sel),
    .pin_direction_bit(dir), .pin_function_select(sel), .port_mapping_code(cd),
    .lcd_segment_enable(seg), .gpio_out(gpio_out), .mapped_out(mapped_out), .mapped_oe(moe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .schmitt_en(sch), .gpio_in(gin),
    .mapped_in(min), .lcd_segment_line(lsl), .lcd_bias_node_high(bh), .lcd_bias_node_mid(bm),
    .lcd_bias_node_low(bl), .lcd_reference_input(lri), .pin_function(fn));
  p1fs_far_side p1fs_far_side_i (.clk(clk), .hold(hold), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_in(pad_in), .gpio_out(gpio_out), .mapped_out(mapped_out));
  // One place for every comparison, so counts stay honest
  task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask
  task results;
    $display("mismatches %0d of %0d checks", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Rows first, then segment and bias state left by the last row, data paths, analog reference, clock enable, then a mid-run reset
  initial
  begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    foreach (rows[i])
    begin
      {sel, dir, seg, moe} = {rows[i].sel, rows[i].dir, rows[i].seg, rows[i].moe};
      cd = {8{rows[i].cd}};
      @(negedge clk);
      check("pad_oe", {32'h0, pad_oe}, {32'h0, rows[i].oe});
      check("pin_function", fn, rows[i].fn);
    end
    check("lcd_segment_line", {35'h0, lsl}, 40'h1F);
    check("bias_nodes", {38'h0, bh, bl}, 40'h3);
    // Data paths with the far side frozen, plain I/O then mapped
    hold = 1'b1;
    {sel, dir, seg} = {8'h00, 8'h0F, 5'h00};
    repeat (6) @(negedge clk);
    check("gpio_pad_out", {32'h0, pad_out}, {32'h0, gpio_out});
    check("gpio_in", {32'h0, gin}, {32'h0, pad_in});
    check("mapped_in_idle", {32'h0, min}, 40'h0);
    {sel, moe} = {8'hFF, 8'hF0};
    cd = {8{5'h00}};
    repeat (6) @(negedge clk);
    check("mapped_pad_out", {32'h0, pad_out}, {32'h0, mapped_out});
    check("mapped_in", {32'h0, min}, {32'h0, pad_in});
    check("gpio_in_idle", {32'h0, gin}, 40'h0);
    check("mapped_oe", {32'h0, pad_oe}, 40'hF0);
    // Analog code everywhere, then the middle tap becomes the reference input
    cd = {8{5'h1F}};
    @(negedge clk);
    check("schmitt_off", {32'h0, sch}, 40'h0);
    check("mid_ref", {38'h0, bm, lri}, 40'h2);
    ref_sel = 1'b1;
    repeat (2) @(negedge clk);
    check("mid_ref_sel", {38'h0, bm, lri}, 40'h1);
    ref_sel = 1'b0;
    // Clock enable low freezes all state
    ce = 1'b0;
    sel = 8'h00;
    repeat (2) @(negedge clk);
    check("ce_freeze", fn, {{3{5'h10}}, {5{5'h04}}});
    ce = 1'b1;
    @(negedge clk);
    check("ce_resume", fn, {8{5'h01}});
    srst = 1'b1;
    @(negedge clk);
    check("reset_function", fn, {8{5'h01}});
    check("reset_outputs", {27'h0, pad_oe, lsl}, 40'h0);
    // Leave reset mid-run and see the block answer again
    srst = 1'b0;
    {sel, moe} = {8'hFF, 8'h3C};
    cd = {8{5'h1E}};
    @(negedge clk);
    check("after_reset", {32'h0, pad_oe}, 40'h3C);
    results();
  end
endmodule
bind p1fs_port_select p1fs_checker p1fs_checker_i (.*);
`default_nettype wire
